/* dv/ptf_downlink_sink.sv */
// Purpose: Downlink side model that takes frame bytes from the framer
// Assumes: Ready may be held low or toggled to stall the framer
// Notes: Keeps the last whole frame and counts framing slips
`timescale 1ns/10ps
module ptf_downlink_sink
  import ptf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic hold,
  input wire logic slow,
  input wire logic txValid,
  input wire logic [7:0] txByte,
  input wire logic txFirst,
  input wire logic txLast,
  output logic txReady,
  output logic [7:0] frameBytes [0:23],
  output int frameCount,
  output int slips
);
  logic [4:0] idx;
  logic tick;

  // Slow mode toggles ready so stalls land inside frames
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      tick <= 1'b0;
      txReady <= 1'b0;
      idx <= 5'h00;
      frameCount <= 0;
      slips <= 0;
    end
    else
    begin
      tick <= ~tick;
      txReady <= ~hold & (~slow | tick);
      if (txValid & txReady)
      begin
        frameBytes[idx] <= txByte;
        if (txFirst !== (idx == 5'h00) || txLast !== (idx == POS_FRAME_LAST))
          slips <= slips + 1;
        idx <= txLast ? 5'h00 : idx + 5'h01;
        if (txLast)
          frameCount <= frameCount + 1;
      end
    end
  end
endmodule : ptf_downlink_sink

/* dv/ptf_framer_tb.sv */
// Purpose: Self-checking bench of the telemetry framer
// Assumes: Packet bytes are base+i, so payload is easy to predict
// Notes: Expected check words are worked out here, not taken from the design
`timescale 1ns/10ps
module ptf_framer_tb
  import ptf_pkg::*;
;
  logic sys_clk = 1'b0, reset = 1'b1, loadWrite = 1'b0, loadCommit = 1'b0, txReady;
  logic [2:0] loadSlot = 3'h0;
  logic [4:0] loadIndex = 5'h00;
  logic [7:0] loadByte = 8'h00, txByte, e [0:23], fb [0:23];
  logic [3:0] loadPrio = 4'h0;
  logic [5:0] loadLen = 6'h00;
  logic txValid, txFirst, txLast, hold = 1'b0, slow = 1'b0, seenClear = 1'b1;
  logic [7:0] slotBusy, refreshReq, refreshSeen, expCount = 8'h00;
  logic [15:0] crc, rotating_word_checksum;
  logic [7:0] pay [$];
  int frameCount, slips, taken = 0, failures = 0, samples_checked = 0;

  ptf_framer DUT (.sys_clk(sys_clk), .reset(reset), .loadWrite(loadWrite), .loadSlot(loadSlot),
    .loadIndex(loadIndex), .loadByte(loadByte), .loadCommit(loadCommit), .loadPrio(loadPrio),
    .loadLen(loadLen), .txReady(txReady), .txValid(txValid), .txByte(txByte), .txFirst(txFirst),
    .txLast(txLast), .slotBusy(slotBusy), .refreshReq(refreshReq));
  ptf_downlink_sink sink (.sys_clk(sys_clk), .reset(reset), .hold(hold), .slow(slow),
    .txValid(txValid), .txByte(txByte), .txFirst(txFirst), .txLast(txLast), .txReady(txReady),
    .frameBytes(fb), .frameCount(frameCount), .slips(slips));

  initial
  begin
    forever #10 sys_clk = ~sys_clk;
  end

  // Sticky copy of refresh pulses, held clear until the refresh scenario arms it
  always @(posedge sys_clk)
    refreshSeen <= seenClear ? 8'h00 : (refreshSeen | refreshReq);

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Writes bytes base+i, then commits; pushes them as expected payload when keep is set
  task automatic load_pkt(input logic [2:0] s, input logic [3:0] p, input logic [5:0] n,
    input logic [7:0] base, input bit keep);
    for (int i = 0; i < n; i++)
    begin
      @(posedge sys_clk);
      loadWrite <= 1'b1;
      loadSlot <= s;
      loadIndex <= i[4:0];
      loadByte <= base + i[7:0];
      if (keep)
        pay.push_back(base + i[7:0]);
    end
    @(posedge sys_clk);
    loadWrite <= 1'b0;
    loadCommit <= 1'b1;
    loadPrio <= p;
    loadLen <= n;
    @(posedge sys_clk);
    loadCommit <= 1'b0;
  endtask : load_pkt

  // Waits for the next frame and compares all 24 bytes
  task automatic get_frame(input logic [7:0] info);
    for (int i = 0; i < 3000 && frameCount <= taken; i++)
      @(posedge sys_clk);
    #1;
    taken++;
    e[0] = SYNC_BYTE0;
    e[1] = SYNC_BYTE1;
    e[2] = info;
    e[3] = expCount;
    for (int i = 0; i < 16; i++)
      e[4 + i] = (i < pay.size()) ? pay[i] : PAD_BYTE;
    crc = CRC_INIT;
    rotating_word_checksum = CSM_INIT;
    for (int i = 0; i < 20; i++)
    begin
      crc = crc ^ {e[i], 8'h00};
      repeat (8) crc = crc[15] ? ((crc << 1) ^ CRC_POLY) : (crc << 1);
      if (i % 2 == 1)
      begin
        rotating_word_checksum = rotating_word_checksum + {e[i - 1], e[i]};
        rotating_word_checksum = {rotating_word_checksum[0], rotating_word_checksum[15:1]};
      end
    end
    {e[20], e[21], e[22], e[23]} = {crc, rotating_word_checksum};
    for (int i = 0; i < 24; i++)
      check({8'h00, fb[i]}, {8'h00, e[i]});
    check(16'(frameCount), 16'(taken));
    pay.delete();
    expCount = (expCount == COUNT_LAST) ? 8'h00 : expCount + COUNT_STEP;
  endtask : get_frame

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_never();
    load_pkt(3'h7, 4'hB, 6'h04, 8'h60, 0);
    repeat (300) @(posedge sys_clk);
    check(16'(frameCount), 16'h0000);
    check({15'h0, slotBusy[7]}, 16'h0001);
    // A packet shorter than its header is refused, so nothing is queued
    load_pkt(3'h6, 4'h2, 6'h01, 8'h40, 0);
    repeat (40) @(posedge sys_clk);
    check({15'h0, slotBusy[6]}, 16'h0000);
    check(16'(frameCount), 16'h0000);
    $display("test never_sent done");
  endtask : t_never

  task automatic t_basic();
    load_pkt(3'h0, 4'h3, 6'h04, 8'h10, 1);
    get_frame({4'h3, SEQ_SINGLE, 2'h0});
    check({15'h0, slotBusy[0]}, 16'h0000);
    $display("test basic done");
  endtask : t_basic

  // Later packets queue while the first frame is stalled
  task automatic t_fill();
    hold <= 1'b1;
    load_pkt(3'h0, 4'h4, 6'h02, 8'h20, 1);
    repeat (60) @(posedge sys_clk);
    #1;
    check({txValid, txFirst, 6'h00, txByte}, {2'b11, 6'h00, SYNC_BYTE0});
    load_pkt(3'h1, 4'h5, 6'h0A, 8'h30, 0);
    load_pkt(3'h2, 4'h2, 6'h0A, 8'h50, 0);
    load_pkt(3'h3, 4'h9, 6'h04, 8'h70, 0);
    slow <= 1'b1;
    hold <= 1'b0;
    get_frame({4'h4, SEQ_SINGLE, 2'h0});
    for (int i = 0; i < 10; i++)
      pay.push_back(8'h50 + i[7:0]);
    for (int i = 0; i < 4; i++)
      pay.push_back(8'h70 + i[7:0]);
    get_frame({4'h2, SEQ_SINGLE, 2'h0});
    for (int i = 0; i < 10; i++)
      pay.push_back(8'h30 + i[7:0]);
    get_frame({4'h5, SEQ_SINGLE, 2'h0});
    slow <= 1'b0;
    $display("test fill done");
  endtask : t_fill

  task automatic t_refresh();
    hold <= 1'b1;
    load_pkt(3'h0, 4'h1, 6'h10, 8'h80, 1);
    load_pkt(3'h1, 4'hA, 6'h04, 8'hA0, 0);
    // No frame has retired under the hold, so arming now misses no pulse
    seenClear <= 1'b0;
    hold <= 1'b0;
    get_frame({4'h1, SEQ_SINGLE, 2'h0});
    repeat (3) @(posedge sys_clk);
    check({8'h00, refreshSeen}, 16'h0002);
    for (int i = 0; i < 4; i++)
      pay.push_back(8'hA0 + i[7:0]);
    get_frame({4'hA, SEQ_SINGLE, 2'h0});
    $display("test refresh done");
  endtask : t_refresh

  task automatic t_split();
    load_pkt(3'h0, 4'h1, 6'h20, 8'hC0, 1);
    pay = pay[0:15];
    get_frame({4'h1, SEQ_FIRST, 2'h0});
    for (int i = 0; i < 16; i++)
      pay.push_back(8'hD0 + i[7:0]);
    get_frame({4'h1, SEQ_LAST, 2'h1});
    check({15'h0, slotBusy[0]}, 16'h0000);
    $display("test split done");
  endtask : t_split

  // Runs past the counter's top value so it wraps to zero
  task automatic t_wrap();
    repeat (250)
    begin
      load_pkt(3'h2, 4'h6, 6'h02, 8'hE0, 1);
      get_frame({4'h6, SEQ_SINGLE, 2'h0});
    end
    check(16'(slips), 16'h0000);
    $display("test wrap done");
  endtask : t_wrap

  initial
  begin
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    t_never();
    t_basic();
    t_fill();
    t_refresh();
    t_split();
    t_wrap();
    wrap_up();
  end

  // Whole run needs about 15000 cycles; this cuts a hang short
  initial
  begin
    repeat (60000) @(posedge sys_clk);
    failures++;
    wrap_up();
  end
endmodule : ptf_framer_tb

/* rtl/ptf_check_gen.sv */
// Purpose: Running CRC and rotating word checksum over frame bytes
// Assumes: Bytes arrive high byte first within each 16-bit word
// Notes: Odd trailing byte is held and never added
`timescale 1ns/10ps
module ptf_check_gen
  import ptf_pkg::*;
#(
  parameter logic [15:0] POLY = CRC_POLY,
  parameter logic [15:0] INIT = CRC_INIT
)
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clear,
  input wire logic step,
  input wire logic [7:0] dataByte,
  output logic [15:0] crcValue,
  output logic [15:0] csmValue
);

  typedef struct packed {
    logic [15:0] crc;
    logic [15:0] rotating_word_checksum;
    logic [7:0] hiByte;
    logic haveHi;
  } ptf_chk_t;

  ptf_chk_t chk_reg;
  ptf_chk_t chk_next;

  // Bitwise CRC step, MSB first
  function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] v;
    v = c;
    for (int i = 7; i >= 0; i--)
    begin
      v = (v[15] ^ b[i]) ? ({v[14:0], 1'b0} ^ POLY) : {v[14:0], 1'b0};
    end
    return v;
  endfunction : crcByte

  // Accumulate with the carry out of bit 15 dropped, then rotate right by one bit
  always_comb
  begin
    logic [15:0] sum;
    sum = '0;
    chk_next = chk_reg;
    if (clear)
    begin
      chk_next.crc = INIT;
      chk_next.rotating_word_checksum = CSM_INIT;
      chk_next.haveHi = 1'b0;
    end
    else if (step)
    begin
      chk_next.crc = crcByte(chk_reg.crc, dataByte);
      if (!chk_reg.haveHi)
      begin
        chk_next.hiByte = dataByte;
        chk_next.haveHi = 1'b1;
      end
      else
      begin
        sum = chk_reg.rotating_word_checksum + {chk_reg.hiByte, dataByte};
        chk_next.rotating_word_checksum = {sum[0], sum[15:1]};
        chk_next.haveHi = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      chk_reg <= '0;
    end
    else
    begin
      chk_reg <= chk_next;
    end
  end

  assign crcValue = chk_reg.crc;
  assign csmValue = chk_reg.rotating_word_checksum;

endmodule : ptf_check_gen

/* rtl/ptf_framer.sv */
// Purpose: Builds 24-byte telemetry frames from a queue of prioritised packets
// Assumes: Producers load packet bytes, then commit priority and length
// Notes: A slot must not be reloaded while its packet is being split
// Operation
// - Every frame is exactly 24 bytes
// - Frame opens with two sync bytes
// - Info byte: top priority, sequence control, count
// - 8-bit frame counter, modulo 255, per frame
// - Packets fill bytes four to nineteen
// - Two-byte CRC over frame data
// - Two-byte checksum, add word then rotate
// - Eleven levels, one most urgent
// - Level eleven is never sent
// - Urgent first; oversize first packet splits
// - Then smaller packets fill leftover space
// - Release only after header and trailer
// - Unplaced packets wait for next pass
// - Levels eight to ten refresh each pass
// - Packets start with origin and item identifiers
`timescale 1ns/10ps
module ptf_framer
  import ptf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic loadWrite,
  input wire logic [SLOT_W-1:0] loadSlot,
  input wire logic [4:0] loadIndex,
  input wire logic [7:0] loadByte,
  input wire logic loadCommit,
  input wire logic [3:0] loadPrio,
  input wire logic [LEN_W-1:0] loadLen,
  input wire logic txReady,
  output logic txValid,
  output logic [7:0] txByte,
  output logic txFirst,
  output logic txLast,
  output logic [NUM_SLOTS-1:0] slotBusy,
  output logic [NUM_SLOTS-1:0] refreshReq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    ptf_state_t state;
    logic [NUM_SLOTS-1:0] slotValid;
    logic [NUM_SLOTS-1:0][3:0] slotPrio;
    logic [NUM_SLOTS-1:0][LEN_W-1:0] slotLen;
    logic [NUM_SLOTS-1:0] placed;
    logic [PAYLOAD_BYTES-1:0][7:0] payload;
    logic [4:0] fill;
    logic urgent;
    logic [SLOT_W-1:0] curSlot;
    logic [4:0] srcIdx;
    logic [LEN_W-1:0] copyLeft;
    logic [3:0] topPrio;
    logic [1:0] seqCtl;
    logic [1:0] seqCnt;
    logic splitOn;
    logic [SLOT_W-1:0] splitSlot;
    logic [LEN_W-1:0] splitOff;
    logic [7:0] msgCount;
    logic [4:0] frameIdx;
    logic txValid;
    logic [7:0] txByte;
    logic txFirst;
    logic txLast;
    logic [NUM_SLOTS-1:0] refreshReq;
  } ptf_frm_t;

  ptf_frm_t frm_reg;
  ptf_frm_t frm_next;

  // Packet bytes of every slot; the header bytes lead each packet
  logic [7:0] slotMem [NUM_SLOTS][MAX_PKT];
  logic [15:0] crcValue;
  logic [15:0] csmValue;
  logic chkClear;
  logic chkStep;
  logic [7:0] chkByte;

  // header travels inside the packet, parsed on ground
  always_ff @(posedge sys_clk)
  begin
    if (loadWrite)
    begin
      slotMem[loadSlot][loadIndex] <= loadByte;
    end
  end

  // ----------------------------------------------------------------
  // Frame byte selection
  // ----------------------------------------------------------------
  function automatic logic [7:0] frameByte(input ptf_frm_t f, input logic [15:0] crc, input logic [15:0] rotating_word_checksum);
    logic [4:0] pos;
    logic [7:0] b;
    pos = f.frameIdx - POS_PAY_FIRST;
    b = f.payload[pos[3:0]];
    unique case (f.frameIdx)
      POS_SYNC0: b = SYNC_BYTE0;
      POS_SYNC1: b = SYNC_BYTE1;
      POS_INFO: b = {f.topPrio, f.seqCtl, f.seqCnt};
      POS_COUNT: b = f.msgCount;
      POS_CRC_HI: b = crc[15:8];
      POS_CRC_LO: b = crc[7:0];
      POS_CSM_HI: b = rotating_word_checksum[15:8];
      POS_CSM_LO: b = rotating_word_checksum[7:0];
      default: b = f.payload[pos[3:0]];
    endcase
    return b;
  endfunction : frameByte

  // ----------------------------------------------------------------
  // Candidate search
  // ----------------------------------------------------------------
  logic [NUM_SLOTS-1:0] eligible;
  logic [NUM_SLOTS-1:0] fits;
  logic [LEN_W-1:0] freeSpace;

  assign freeSpace = PAYLOAD_LEN - {1'b0, frm_reg.fill};

  genvar gs;
  generate
    for (gs = 0; gs < NUM_SLOTS; gs++)
    begin : g_slot
      // levels one to ten only; left over slots stay eligible
      assign eligible[gs] = frm_reg.slotValid[gs] && !frm_reg.placed[gs] &&
                            frm_reg.slotPrio[gs] >= PRIO_TOP && frm_reg.slotPrio[gs] <= PRIO_LAST_SENT;
      assign fits[gs] = eligible[gs] && frm_reg.slotLen[gs] <= freeSpace;
    end
  endgenerate

  // Most urgent slot of a mask, lowest slot wins a tie
  function automatic logic [SLOT_W:0] bestOf(input logic [NUM_SLOTS-1:0] m,
                                             input logic [NUM_SLOTS-1:0][3:0] p);
    logic [3:0] bp;
    logic [SLOT_W:0] res;
    bp = PRIO_NONE;
    res = '0;
    for (int i = NUM_SLOTS - 1; i >= 0; i--)
    begin
      if (m[i] && p[i] <= bp)
      begin
        bp = p[i];
        res = {1'b1, SLOT_W'(i)};
      end
    end
    return res;
  endfunction : bestOf

  logic [SLOT_W:0] bestAny;
  logic [SLOT_W:0] bestFit;

  assign bestAny = bestOf(eligible, frm_reg.slotPrio);
  assign bestFit = bestOf(fits, frm_reg.slotPrio);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [SLOT_W-1:0] sel;
    logic [LEN_W-1:0] rem;
    sel = '0;
    rem = '0;
    frm_next = frm_reg;
    frm_next.refreshReq = '0;
    chkClear = 1'b0;
    chkStep = 1'b0;
    chkByte = frameByte(frm_reg, crcValue, csmValue);
    unique case (frm_reg.state)
      ST_IDLE:
      begin
        frm_next.fill = '0;
        frm_next.placed = '0;
        frm_next.urgent = 1'b1;
        frm_next.topPrio = PRIO_NONE;
        frm_next.seqCtl = SEQ_SINGLE;
        frm_next.payload = {PAYLOAD_BYTES{PAD_BYTE}};
        chkClear = 1'b1;
        if (frm_reg.splitOn)
        begin
          // next segment of a split packet
          sel = frm_reg.splitSlot;
          rem = frm_reg.slotLen[sel] - frm_reg.splitOff;
          frm_next.curSlot = sel;
          frm_next.srcIdx = frm_reg.splitOff[4:0];
          frm_next.copyLeft = (rem > PAYLOAD_LEN) ? PAYLOAD_LEN : rem;
          frm_next.seqCtl = (rem > PAYLOAD_LEN) ? SEQ_CONT : SEQ_LAST;
          frm_next.topPrio = frm_reg.slotPrio[sel];
          frm_next.state = ST_COPY;
        end
        else if (bestAny[SLOT_W])
        begin
          frm_next.seqCnt = '0;
          frm_next.state = ST_PICK;
        end
      end
      ST_PICK:
      begin
        sel = bestFit[SLOT_W-1:0];
        if (frm_reg.urgent && !bestAny[SLOT_W])
        begin
          frm_next.state = ST_CHECK;
        end
        // urgent pass takes the head while it fits
        else if (frm_reg.urgent && !fits[bestAny[SLOT_W-1:0]])
        begin
          sel = bestAny[SLOT_W-1:0];
          if (frm_reg.fill == '0)
          begin
            // oversize head opens a split sequence
            frm_next.splitOn = 1'b1;
            frm_next.splitSlot = sel;
            frm_next.splitOff = '0;
            frm_next.curSlot = sel;
            frm_next.srcIdx = '0;
            frm_next.copyLeft = PAYLOAD_LEN;
            frm_next.seqCtl = SEQ_FIRST;
            frm_next.topPrio = frm_reg.slotPrio[sel];
            frm_next.state = ST_COPY;
          end
          else
          begin
            frm_next.urgent = 1'b0;
          end
        end
        else if (!bestFit[SLOT_W])
        begin
          frm_next.state = ST_CHECK;
        end
        else
        begin
          if (!frm_reg.urgent || fits[bestAny[SLOT_W-1:0]])
          begin
            sel = frm_reg.urgent ? bestAny[SLOT_W-1:0] : bestFit[SLOT_W-1:0];
          end
          frm_next.curSlot = sel;
          frm_next.srcIdx = '0;
          frm_next.copyLeft = frm_reg.slotLen[sel];
          frm_next.placed[sel] = 1'b1;
          if (frm_reg.slotPrio[sel] < frm_reg.topPrio)
          begin
            frm_next.topPrio = frm_reg.slotPrio[sel];
          end
          frm_next.state = ST_COPY;
        end
      end
      ST_COPY:
      begin
        frm_next.payload[frm_reg.fill[3:0]] = slotMem[frm_reg.curSlot][frm_reg.srcIdx];
        frm_next.fill = frm_reg.fill + STEP_ONE;
        frm_next.srcIdx = frm_reg.srcIdx + STEP_ONE;
        frm_next.copyLeft = frm_reg.copyLeft - LEN_ONE;
        if (frm_reg.copyLeft == LEN_ONE)
        begin
          frm_next.frameIdx = CHECK_FIRST;
          frm_next.state = frm_reg.splitOn ? ST_CHECK : ST_PICK;
        end
      end
      ST_CHECK:
      begin
        // covered span is a named range
        chkStep = 1'b1;
        frm_next.frameIdx = frm_reg.frameIdx + STEP_ONE;
        if (frm_reg.frameIdx == CHECK_LAST)
        begin
          frm_next.frameIdx = POS_SYNC0;
          frm_next.txValid = 1'b1;
          frm_next.txByte = SYNC_BYTE0;
          frm_next.txFirst = 1'b1;
          frm_next.txLast = 1'b0;
          frm_next.state = ST_SEND;
        end
      end
      ST_SEND:
      begin
        if (txReady)
        begin
          if (frm_reg.frameIdx == POS_FRAME_LAST)
          begin
            frm_next.txValid = 1'b0;
            frm_next.txLast = 1'b0;
            frm_next.state = ST_RETIRE;
          end
          else
          begin
            frm_next.frameIdx = frm_reg.frameIdx + STEP_ONE;
            frm_next.txByte = frameByte(frm_next, crcValue, csmValue);
            frm_next.txFirst = 1'b0;
            frm_next.txLast = (frm_next.frameIdx == POS_FRAME_LAST);
          end
        end
      end
      ST_RETIRE:
      begin
        frm_next.msgCount = (frm_reg.msgCount == COUNT_LAST) ? '0 : frm_reg.msgCount + COUNT_STEP;
        if (frm_reg.splitOn)
        begin
          frm_next.seqCnt = frm_reg.seqCnt + SEQ_STEP;
          frm_next.splitOff = frm_reg.splitOff + PAYLOAD_LEN;
          if (frm_next.splitOff >= frm_reg.slotLen[frm_reg.splitSlot])
          begin
            frm_next.splitOn = 1'b0;
            frm_next.placed[frm_reg.splitSlot] = 1'b1;
          end
        end
        // only sent packets leave; refresh asked for levels eight to ten
        for (int i = 0; i < NUM_SLOTS; i++)
        begin
          if (frm_next.placed[i])
          begin
            frm_next.slotValid[i] = 1'b0;
          end
          frm_next.refreshReq[i] = frm_reg.slotValid[i] && frm_reg.slotPrio[i] >= PRIO_REFRESH_LO &&
                                   frm_reg.slotPrio[i] <= PRIO_REFRESH_HI;
        end
        frm_next.state = ST_IDLE;
      end
      default:
      begin
        frm_next.state = ST_IDLE;
      end
    endcase
    // A commit in the retire cycle wins over the clear
    if (loadCommit && loadLen >= PKT_HDR_BYTES && loadLen <= PKT_MAX_LEN)
    begin
      frm_next.slotValid[loadSlot] = 1'b1;
      frm_next.slotPrio[loadSlot] = loadPrio;
      frm_next.slotLen[loadSlot] = loadLen;
    end
  end

  // State register
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      frm_reg <= '0;
    end
    else
    begin
      frm_reg <= frm_next;
    end
  end

  ptf_check_gen #(
    .POLY(CRC_POLY),
    .INIT(CRC_INIT)
  ) u_check (
    .sys_clk(sys_clk),
    .reset(reset),
    .clear(chkClear),
    .step(chkStep),
    .dataByte(chkByte),
    .crcValue(crcValue),
    .csmValue(csmValue)
  );

  assign txValid = frm_reg.txValid;
  assign txByte = frm_reg.txByte;
  assign txFirst = frm_reg.txFirst;
  assign txLast = frm_reg.txLast;
  assign slotBusy = frm_reg.slotValid;
  assign refreshReq = frm_reg.refreshReq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  a_frame_length: assert property (txValid && txLast |-> frm_reg.frameIdx == POS_FRAME_LAST && !txFirst)
    else $error("last byte not at position 23");
  a_sync_second: assert property (txValid && txFirst && txReady |=> txValid && txByte == SYNC_BYTE1)
    else $error("second sync byte wrong");
  a_info_prio: assert property (txValid && frm_reg.frameIdx == POS_INFO |->
                                txByte[7:4] >= PRIO_TOP && txByte[7:4] <= PRIO_LAST_SENT)
    else $error("info byte carries unsendable priority");
  a_count_step: assert property (frm_reg.state == ST_RETIRE |=> frm_reg.msgCount ==
                                 (($past(frm_reg.msgCount) == COUNT_LAST) ? 8'h00 : $past(frm_reg.msgCount) + COUNT_STEP))
    else $error("frame counter step wrong");
  a_payload_bound: assert property (frm_reg.fill <= PAYLOAD_LEN[4:0])
    else $error("payload overfilled");
  a_release_late: assert property (txValid |-> frm_reg.state == ST_SEND)
    else $error("byte released outside send");
  a_stall_hold: assert property (txValid && !txReady |=> txValid && $stable(txByte) && $stable(frm_reg.frameIdx))
    else $error("byte changed under stall");
  a_refresh_band: assert property (refreshReq[1] |-> $past(frm_reg.slotPrio[1]) >= PRIO_REFRESH_LO &&
                                   $past(frm_reg.slotPrio[1]) <= PRIO_REFRESH_HI)
    else $error("refresh asked outside levels eight to ten");
  a_crc_before: assert property (frm_reg.state == ST_CHECK && frm_reg.frameIdx == CHECK_LAST |=> txFirst && txValid)
    else $error("frame not released after trailer");

  c_frame_sent: cover property (txValid && txLast && txReady);
  c_split_seq: cover property (frm_reg.splitOn && frm_reg.state == ST_RETIRE);
  c_fill_pass: cover property (frm_reg.state == ST_PICK && !frm_reg.urgent && bestFit[SLOT_W]);
  c_count_wrap: cover property (frm_reg.state == ST_RETIRE && frm_reg.msgCount == COUNT_LAST);

endmodule : ptf_framer

/* rtl/ptf_pkg.sv */
// Purpose: Shared constants and types of the priority telemetry framer
// Assumes: One byte lane toward the downlink, one clock
// Notes: Frame layout positions, priority levels and check settings live here
package ptf_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam logic [4:0] POS_SYNC0 = 5'h00;
  localparam logic [4:0] POS_SYNC1 = 5'h01;
  localparam logic [4:0] POS_INFO = 5'h02;
  localparam logic [4:0] POS_COUNT = 5'h03;
  localparam logic [4:0] POS_PAY_FIRST = 5'h04;
  localparam logic [4:0] POS_PAY_LAST = 5'h13;
  localparam logic [4:0] POS_CRC_HI = 5'h14;
  localparam logic [4:0] POS_CRC_LO = 5'h15;
  localparam logic [4:0] POS_CSM_HI = 5'h16;
  localparam logic [4:0] POS_CSM_LO = 5'h17;
  localparam logic [4:0] POS_FRAME_LAST = 5'h17;
  localparam logic [4:0] STEP_ONE = 5'h01;
  localparam int PAYLOAD_BYTES = 16;
  localparam logic [5:0] PAYLOAD_LEN = 6'h10;
  localparam logic [7:0] SYNC_BYTE0 = 8'hEB;
  localparam logic [7:0] SYNC_BYTE1 = 8'h90;
  localparam logic [7:0] PAD_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // Counter, queue and packets
  // ----------------------------------------------------------------
  localparam logic [7:0] COUNT_LAST = 8'hFE;
  localparam logic [7:0] COUNT_STEP = 8'h01;
  localparam int NUM_SLOTS = 8;
  localparam int SLOT_W = 3;
  localparam int MAX_PKT = 32;
  localparam int LEN_W = 6;
  localparam logic [5:0] LEN_ONE = 6'h01;
  localparam logic [5:0] PKT_HDR_BYTES = 6'h02;
  localparam logic [5:0] PKT_MAX_LEN = 6'h20;

  // ----------------------------------------------------------------
  // Priorities and message info fields
  // ----------------------------------------------------------------
  localparam logic [3:0] PRIO_TOP = 4'h1;
  localparam logic [3:0] PRIO_LAST_SENT = 4'hA;
  localparam logic [3:0] PRIO_REFRESH_LO = 4'h8;
  localparam logic [3:0] PRIO_REFRESH_HI = 4'hA;
  localparam logic [3:0] PRIO_NONE = 4'hF;
  localparam logic [1:0] SEQ_SINGLE = 2'h0;
  localparam logic [1:0] SEQ_FIRST = 2'h1;
  localparam logic [1:0] SEQ_CONT = 2'h2;
  localparam logic [1:0] SEQ_LAST = 2'h3;
  localparam logic [1:0] SEQ_STEP = 2'h1;

  // ----------------------------------------------------------------
  // Check values over the frame
  // ----------------------------------------------------------------
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CSM_INIT = 16'h0000;
  localparam logic [4:0] CHECK_FIRST = 5'h00;
  localparam logic [4:0] CHECK_LAST = 5'h13;

  typedef enum logic [2:0] {ST_IDLE, ST_PICK, ST_COPY, ST_CHECK, ST_SEND, ST_RETIRE} ptf_state_t;

endpackage : ptf_pkg
